// ---- include/timer_array_pkg.sv ----
// Purpose: Shared constants and carriers for the timer/event counter array
// Assumes: One clock, synchronous active-high reset, byte-wide register port
// Notes: Address bits [7:4] select a channel, bits [3:0] select its register
package timer_array_pkg;
	localparam int NUM_CH = 11;
	localparam int CNT_W = 16;
	localparam int LAST_CH = NUM_CH - 1;
	localparam int NUM_PIN_CH = 3;
	localparam int NUM_FF_PINS = 10;
	// Capture trigger sources by channel index
	localparam int TRIG_SRC_LO = 9;
	localparam int TRIG_SRC_HI = 3;
	localparam int TRIG_SPLIT = 5;

	// Per-channel register offsets (low nibble of the address)
	localparam logic [3:0] OFS_RUN = 4'h0;
	localparam logic [3:0] OFS_CTRL = 4'h1;
	localparam logic [3:0] OFS_MODE = 4'h2;
	localparam logic [3:0] OFS_FFCTRL = 4'h3;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_PRESET_LO = 4'h5;
	localparam logic [3:0] OFS_PRESET_HI = 4'h6;
	localparam logic [3:0] OFS_CMP0_LO = 4'h7;
	localparam logic [3:0] OFS_CMP0_HI = 4'h8;
	localparam logic [3:0] OFS_CMP1_LO = 4'h9;
	localparam logic [3:0] OFS_CMP1_HI = 4'hA;
	localparam logic [3:0] OFS_CAP0_LO = 4'hB;
	localparam logic [3:0] OFS_CAP0_HI = 4'hC;
	localparam logic [3:0] OFS_CAP1_LO = 4'hD;
	localparam logic [3:0] OFS_CAP1_HI = 4'hE;
	// Global page holds the prescaler input select
	localparam logic [3:0] GLOBAL_PAGE = 4'hF;
	localparam logic [3:0] OFS_PRE_SEL = 4'h0;

	// Field positions
	localparam int RUN_CNT_BIT = 0;
	localparam int RUN_PRE_BIT = 2;
	localparam int CTRL_DBUF_BIT = 0;
	localparam int CTRL_CAP_LSB = 1;
	localparam int CTRL_CLR_BIT = 3;
	localparam int MODE_CLK_LSB = 0;
	localparam int MODE_OP_LSB = 2;
	localparam int FF_CMD_LSB = 0;
	localparam int FF_INV_M0_BIT = 2;
	localparam int FF_INV_M1_BIT = 3;
	localparam int FF_INV_C0_BIT = 4;
	localparam int FF_INV_C1_BIT = 5;
	localparam int ST_M0_BIT = 0;
	localparam int ST_M1_BIT = 1;
	localparam int ST_OVF_BIT = 2;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] RST_CMP = 16'hFFFF;
	localparam logic [1:0] RST_PRE_SEL = 2'h0;
	localparam logic [5:0] RST_FFCTRL = 6'h00;

	// Operating modes
	localparam logic [1:0] OP_INTERVAL = 2'h0;
	localparam logic [1:0] OP_EVENT = 2'h1;
	localparam logic [1:0] OP_SQUARE = 2'h2;
	localparam logic [1:0] OP_QUAD = 2'h3;
	// Count clock selects
	localparam logic [1:0] CLK_EXT = 2'h0;
	localparam logic [1:0] CLK_T1 = 2'h1;
	localparam logic [1:0] CLK_T4 = 2'h2;
	localparam logic [1:0] CLK_T16 = 2'h3;
	// Capture modes
	localparam logic [1:0] CAP_OFF = 2'h0;
	localparam logic [1:0] CAP_EXT = 2'h1;
	localparam logic [1:0] CAP_WIDTH = 2'h2;
	localparam logic [1:0] CAP_INT = 2'h3;
	// Flip-flop commands
	localparam logic [1:0] FF_INVERT = 2'h0;
	localparam logic [1:0] FF_SET = 2'h1;
	localparam logic [1:0] FF_CLEAR = 2'h2;
	localparam logic [1:0] FF_KEEP = 2'h3;
	// Prescaler: 5-bit counter, input divider up to 16
	localparam int PRE_W = 5;
	localparam int DIV_W = 4;
	localparam logic [4:0] PRE_T4_MASK = 5'h07;
	localparam logic [4:0] PRE_T16_MASK = 5'h1F;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bus_req_s;

	typedef struct packed {
		logic t1;
		logic t4;
		logic t16;
	} pre_ticks_s;
endpackage : timer_array_pkg

// ---- core/chan_prescaler.sv ----
// Purpose: Per-channel input divider and 5-bit prescaler giving count ticks
// Assumes: Ticks are one-cycle pulses on the system clock
// Notes: Clearing run resets both counters so restart phase is known
`timescale 1ns/1ps
module chan_prescaler (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic run_in,
	input wire logic [1:0] sel_in,
	output timer_array_pkg::pre_ticks_s ticks_out
);
	logic [timer_array_pkg::DIV_W-1:0] div_q;
	logic [timer_array_pkg::PRE_W-1:0] pre_q;
	logic [timer_array_pkg::DIV_W-1:0] div_mask;
	logic in_tick;

	// Select 00 divides by 16, 11 by 2
	always_comb
	begin
		case (sel_in)
			2'h0: div_mask = 4'hF;
			2'h1: div_mask = 4'h7;
			2'h2: div_mask = 4'h3;
			default: div_mask = 4'h1;
		endcase
	end

	assign in_tick = run_in && ((div_q & div_mask) == div_mask);

	// Input divider
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in || !run_in)
			div_q <= '0;
		else
			div_q <= div_q + 4'h1;
	end

	// Five-bit prescaler on divided ticks
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in || !run_in)
			pre_q <= '0;
		else if (in_tick)
			pre_q <= pre_q + 5'h01;
	end

	// Taps at /2, /8 and /32 of the prescaler input
	assign ticks_out.t1 = in_tick && pre_q[0];
	assign ticks_out.t4 = in_tick &&
		((pre_q & timer_array_pkg::PRE_T4_MASK) ==
		timer_array_pkg::PRE_T4_MASK);
	assign ticks_out.t16 = in_tick &&
		(pre_q == timer_array_pkg::PRE_T16_MASK);
endmodule : chan_prescaler

// ---- core/timer_event_array.sv ----
// Purpose: Eleven independent 16-bit timer/event counter channels
// Assumes: Pins are synchronous to sys_clk_in; byte-wide register port
// Notes: Pin index 0,1 serve channels 0,1; index 2 serves the last channel
// Overview of operation
// - Eleven channels, each with its own 16-bit timer/event counter.
// - Interval, event, square-wave modes; two-phase counting on last only.
// - Captures support frequency, pulse width and time difference uses.
// - 16-bit up-counter, up/down on last in two-phase mode; two compare registers, second double-buffered.
// - Two capture registers, two comparators, capture control, flip-flop.
// - Channels run independently with identical behaviour otherwise.
// - Only channels 0, 1 and last have two external clock/capture pins.
// - Channels 0 to 9 drive flip-flop pins; last channel has none.
// - Capture trigger: channel 9 flip-flop for 0-4, channel 3 for rest.
// - Run, control, mode, flip-flop, status, preset, compare, capture regs.
// - Count clock via 5-bit prescaler fed by clock divided 2, 4, 8, 16.
// - Prescaler run bit 1 starts counting, 0 clears and stops.
`timescale 1ns/1ps
module timer_event_array (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input timer_array_pkg::bus_req_s reg_req_in,
	input wire logic [2:0] ext_clock_capture_in0_in,
	input wire logic [2:0] ext_capture_in1_in,
	output logic [7:0] rd_data_out,
	output logic [9:0] flipflop_output_pin_out,
	output logic [10:0] irq_req_out
);
	localparam int N = timer_array_pkg::NUM_CH;

	logic [7:0] rd_byte [N];
	logic [N-1:0] ff_w;
	logic [N-1:0] flag_w;
	logic [1:0] pre_sel_q;
	logic [3:0] acc_page;
	logic [3:0] acc_ofs;

	// Map a channel to its external pin index, or none
	function automatic int pin_index(input int ch);
		if (ch == 0)
			return 0;
		else if (ch == 1)
			return 1;
		else if (ch == timer_array_pkg::LAST_CH)
			return 2;
		return -1;
	endfunction : pin_index

	// Pick a 16-bit half by address parity of the low/high pair
	function automatic logic [7:0] half(input logic [15:0] v,
		input logic hi);
		return hi ? v[15:8] : v[7:0];
	endfunction : half

	assign acc_page = reg_req_in.addr[7:4];
	assign acc_ofs = reg_req_in.addr[3:0];

	// Global prescaler input select
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			pre_sel_q <= timer_array_pkg::RST_PRE_SEL;
		else if (reg_req_in.wr && acc_page == timer_array_pkg::GLOBAL_PAGE &&
			acc_ofs == timer_array_pkg::OFS_PRE_SEL)
			pre_sel_q <= reg_req_in.wdata[1:0];
	end

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_ch
			localparam int PIN = pin_index(gi);
			localparam bit IS_LAST = (gi == timer_array_pkg::LAST_CH);
			localparam int TRIG = (gi < timer_array_pkg::TRIG_SPLIT) ?
				timer_array_pkg::TRIG_SRC_LO : timer_array_pkg::TRIG_SRC_HI;
			logic [7:0] run_q, ctrl_q, mode_q;
			logic [5:0] ffc_q;
			logic [2:0] st_q;
			logic [15:0] cnt_q, cnt_d, cmp0_q, cmp1_q, cmp1_buf_q;
			logic [15:0] cap0_q, cap1_q;
			logic ff_q, in0, in1, in0_p, in1_p, trig_p;
			logic sel, wr, rd_st, step, up, down, clr, m0, m1, ovf;
			logic cap0_ev, cap1_ev;
			logic [1:0] op, cap_mode;
			timer_array_pkg::pre_ticks_s ticks;

			// Channels 2..9 have no pins, so inputs stay low
			if (PIN >= 0)
			begin : g_pins
				assign in0 = ext_clock_capture_in0_in[PIN];
				assign in1 = ext_capture_in1_in[PIN];
			end
			else
			begin : g_nopins
				assign in0 = 1'b0;
				assign in1 = 1'b0;
			end

			assign sel = (acc_page == 4'(gi));
			assign wr = reg_req_in.wr && sel;
			assign rd_st = reg_req_in.rd && sel &&
				acc_ofs == timer_array_pkg::OFS_STATUS;
			assign op = mode_q[timer_array_pkg::MODE_OP_LSB +: 2];
			assign cap_mode = ctrl_q[timer_array_pkg::CTRL_CAP_LSB +: 2];

			chan_prescaler u_pre (
				.sys_clk_in(sys_clk_in),
				.sys_rst_in(sys_rst_in),
				.run_in(run_q[timer_array_pkg::RUN_PRE_BIT]),
				.sel_in(pre_sel_q),
				.ticks_out(ticks)
			);

			// Control registers; reserved bits of run read back as zero
			always_ff @(posedge sys_clk_in)
			begin
				if (sys_rst_in)
				begin
					run_q <= timer_array_pkg::RST_BYTE;
					ctrl_q <= timer_array_pkg::RST_BYTE;
					mode_q <= timer_array_pkg::RST_BYTE;
					ffc_q <= timer_array_pkg::RST_FFCTRL;
				end
				else if (wr)
				begin
					case (acc_ofs)
						timer_array_pkg::OFS_RUN: run_q <= reg_req_in.wdata & 8'h05;
						timer_array_pkg::OFS_CTRL: ctrl_q <= reg_req_in.wdata & 8'h0F;
						timer_array_pkg::OFS_MODE: mode_q <= reg_req_in.wdata & 8'h0F;
						timer_array_pkg::OFS_FFCTRL: ffc_q <= reg_req_in.wdata[5:0];
						default: ;
					endcase
				end
			end

			// Input history for edge detection
			always_ff @(posedge sys_clk_in)
			begin
				if (sys_rst_in)
				begin
					in0_p <= 1'b0;
					in1_p <= 1'b0;
					trig_p <= 1'b0;
				end
				else
				begin
					in0_p <= in0;
					in1_p <= in1;
					trig_p <= ff_w[TRIG];
				end
			end

			// Count step: quadrature only exists on the last channel
			always_comb
			begin
				up = 1'b0;
				down = 1'b0;
				if (run_q[timer_array_pkg::RUN_CNT_BIT])
				begin
					if (IS_LAST && op == timer_array_pkg::OP_QUAD)
					begin
						// Four counts per phase cycle; a double change is noise
						if ((in0 ^ in0_p) != (in1 ^ in1_p))
						begin
							up = in0 ^ in1_p;
							down = !(in0 ^ in1_p);
						end
					end
					else if (op == timer_array_pkg::OP_EVENT)
						up = in0 && !in0_p;
					else
					begin
						case (mode_q[timer_array_pkg::MODE_CLK_LSB +: 2])
							timer_array_pkg::CLK_EXT: up = in0 && !in0_p;
							timer_array_pkg::CLK_T1: up = ticks.t1;
							timer_array_pkg::CLK_T4: up = ticks.t4;
							default: up = ticks.t16;
						endcase
					end
				end
			end

			// Square-wave mode always clears on the second compare
			assign clr = up && cnt_q == cmp1_q &&
				(ctrl_q[timer_array_pkg::CTRL_CLR_BIT] ||
				op == timer_array_pkg::OP_SQUARE);
			assign step = up || down;

			always_comb
			begin
				if (clr)
					cnt_d = timer_array_pkg::RST_WORD;
				else if (up)
					cnt_d = cnt_q + 16'h0001;
				else if (down)
					cnt_d = cnt_q - 16'h0001;
				else
					cnt_d = cnt_q;
			end

			// Two comparators look at the value just reached
			assign m0 = step && cnt_d == cmp0_q;
			assign m1 = step && cnt_d == cmp1_q;
			assign ovf = up && !clr && cnt_q == 16'hFFFF;

			// Counter with software preset by halves
			always_ff @(posedge sys_clk_in)
			begin
				if (sys_rst_in)
					cnt_q <= timer_array_pkg::RST_WORD;
				else if (wr && acc_ofs == timer_array_pkg::OFS_PRESET_LO)
					cnt_q <= {cnt_q[15:8], reg_req_in.wdata};
				else if (wr && acc_ofs == timer_array_pkg::OFS_PRESET_HI)
					cnt_q <= {reg_req_in.wdata, cnt_q[7:0]};
				else
					cnt_q <= cnt_d;
			end

			// Compare registers; second one is double-buffered when enabled
			always_ff @(posedge sys_clk_in)
			begin
				if (sys_rst_in)
				begin
					cmp0_q <= timer_array_pkg::RST_CMP;
					cmp1_q <= timer_array_pkg::RST_CMP;
					cmp1_buf_q <= timer_array_pkg::RST_CMP;
				end
				else
				begin
					if (wr && acc_ofs == timer_array_pkg::OFS_CMP0_LO)
						cmp0_q[7:0] <= reg_req_in.wdata;
					if (wr && acc_ofs == timer_array_pkg::OFS_CMP0_HI)
						cmp0_q[15:8] <= reg_req_in.wdata;
					if (wr && acc_ofs == timer_array_pkg::OFS_CMP1_LO)
						cmp1_buf_q[7:0] <= reg_req_in.wdata;
					if (wr && acc_ofs == timer_array_pkg::OFS_CMP1_HI)
						cmp1_buf_q[15:8] <= reg_req_in.wdata;
					// Buffered value lands only at a clear, so no glitch period
					if (!ctrl_q[timer_array_pkg::CTRL_DBUF_BIT] || clr)
						cmp1_q <= cmp1_buf_q;
				end
			end

			// Capture events by capture mode
			always_comb
			begin
				cap0_ev = 1'b0;
				cap1_ev = 1'b0;
				case (cap_mode)
					timer_array_pkg::CAP_EXT:
					begin // Time difference between two pins
						cap0_ev = in0 && !in0_p;
						cap1_ev = in1 && !in1_p;
					end
					timer_array_pkg::CAP_WIDTH:
					begin // Pulse width on one pin
						cap0_ev = in0 && !in0_p;
						cap1_ev = !in0 && in0_p;
					end
					timer_array_pkg::CAP_INT:
					begin // Frequency over an internal gate window
						cap0_ev = ff_w[TRIG] && !trig_p;
						cap1_ev = !ff_w[TRIG] && trig_p;
					end
					default: ;
				endcase
			end

			// Capture registers take the live counter
			always_ff @(posedge sys_clk_in)
			begin
				if (sys_rst_in)
				begin
					cap0_q <= timer_array_pkg::RST_WORD;
					cap1_q <= timer_array_pkg::RST_WORD;
				end
				else
				begin
					if (cap0_ev)
						cap0_q <= cnt_q;
					if (cap1_ev)
						cap1_q <= cnt_q;
				end
			end

			// Timer flip-flop: software command beats hardware inversion
			always_ff @(posedge sys_clk_in)
			begin
				if (sys_rst_in)
					ff_q <= 1'b0;
				else if (wr && acc_ofs == timer_array_pkg::OFS_FFCTRL &&
					reg_req_in.wdata[1:0] != timer_array_pkg::FF_KEEP)
				begin
					case (reg_req_in.wdata[1:0])
						timer_array_pkg::FF_SET: ff_q <= 1'b1;
						timer_array_pkg::FF_CLEAR: ff_q <= 1'b0;
						default: ff_q <= !ff_q;
					endcase
				end
				else if ((m0 && (ffc_q[timer_array_pkg::FF_INV_M0_BIT] ||
					op == timer_array_pkg::OP_SQUARE)) ||
					(m1 && (ffc_q[timer_array_pkg::FF_INV_M1_BIT] ||
					op == timer_array_pkg::OP_SQUARE)) ||
					(cap0_ev && ffc_q[timer_array_pkg::FF_INV_C0_BIT]) ||
					(cap1_ev && ffc_q[timer_array_pkg::FF_INV_C1_BIT]))
					ff_q <= !ff_q;
			end
			assign ff_w[gi] = ff_q;

			// Status flags clear on read, but a new event wins
			always_ff @(posedge sys_clk_in)
			begin
				if (sys_rst_in)
					st_q <= 3'h0;
				else
				begin
					st_q[timer_array_pkg::ST_M0_BIT] <= m0 ||
						(st_q[timer_array_pkg::ST_M0_BIT] && !rd_st);
					st_q[timer_array_pkg::ST_M1_BIT] <= m1 ||
						(st_q[timer_array_pkg::ST_M1_BIT] && !rd_st);
					st_q[timer_array_pkg::ST_OVF_BIT] <= ovf ||
						(st_q[timer_array_pkg::ST_OVF_BIT] && !rd_st);
				end
			end
			assign flag_w[gi] = |st_q;

			// Per-channel read byte
			always_comb
			begin
				case (acc_ofs)
					timer_array_pkg::OFS_RUN: rd_byte[gi] = run_q;
					timer_array_pkg::OFS_CTRL: rd_byte[gi] = ctrl_q;
					timer_array_pkg::OFS_MODE: rd_byte[gi] = mode_q;
					timer_array_pkg::OFS_FFCTRL: rd_byte[gi] = {2'h0, ffc_q};
					timer_array_pkg::OFS_STATUS: rd_byte[gi] = {5'h00, st_q};
					timer_array_pkg::OFS_PRESET_LO,
					timer_array_pkg::OFS_PRESET_HI:
						rd_byte[gi] = half(cnt_q, !acc_ofs[0]);
					timer_array_pkg::OFS_CMP0_LO,
					timer_array_pkg::OFS_CMP0_HI:
						rd_byte[gi] = half(cmp0_q, !acc_ofs[0]);
					timer_array_pkg::OFS_CMP1_LO,
					timer_array_pkg::OFS_CMP1_HI:
						rd_byte[gi] = half(cmp1_buf_q, !acc_ofs[0]);
					timer_array_pkg::OFS_CAP0_LO,
					timer_array_pkg::OFS_CAP0_HI:
						rd_byte[gi] = half(cap0_q, !acc_ofs[0]);
					timer_array_pkg::OFS_CAP1_LO,
					timer_array_pkg::OFS_CAP1_HI:
						rd_byte[gi] = half(cap1_q, !acc_ofs[0]);
					default: rd_byte[gi] = 8'h00;
				endcase
			end
		end
	endgenerate

	// Read data stand for one cycle only; unmapped reads give zero
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in || !reg_req_in.rd)
			rd_data_out <= 8'h00;
		else if (acc_page == timer_array_pkg::GLOBAL_PAGE)
			rd_data_out <= (acc_ofs == timer_array_pkg::OFS_PRE_SEL) ?
				{6'h00, pre_sel_q} : 8'h00;
		else if (acc_page < 4'(N))
			rd_data_out <= rd_byte[acc_page];
		else
			rd_data_out <= 8'h00;
	end

	// Pin and request outputs straight from flops
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			flipflop_output_pin_out <= 10'h000;
			irq_req_out <= 11'h000;
		end
		else
		begin
			flipflop_output_pin_out <= ff_w[9:0];
			irq_req_out <= flag_w;
		end
	end
endmodule : timer_event_array

// ---- verif/timer_event_array_assertions.sv ----
// Purpose: Port-level checks for the timer/event counter array
// Assumes: One clock domain, checker sees only the top-level ports
// Notes: Register contents are left to the bench model
`timescale 1ns/1ps
module timer_event_array_assertions (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input timer_array_pkg::bus_req_s reg_req_in,
	input wire logic [2:0] ext_clock_capture_in0_in,
	input wire logic [2:0] ext_capture_in1_in,
	input wire logic [7:0] rd_data_out,
	input wire logic [9:0] flipflop_output_pin_out,
	input wire logic [10:0] irq_req_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	logic [3:0] pg;
	logic [3:0] ofs;
	// Page and offset of the current request
	assign pg = reg_req_in.addr[7:4];
	assign ofs = reg_req_in.addr[3:0];
	sequence chan_rd(o);
		reg_req_in.rd && ofs == o && pg <= 4'hA;
	endsequence
	// Only set and clear give a fixed level; invert depends on history
	sequence ff_cmd;
		reg_req_in.wr && ofs == timer_array_pkg::OFS_FFCTRL && pg <= 4'h9 &&
			(reg_req_in.wdata[1:0] == timer_array_pkg::FF_SET ||
			reg_req_in.wdata[1:0] == timer_array_pkg::FF_CLEAR);
	endsequence
	AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst_in |=>
		rd_data_out == 8'h00 && flipflop_output_pin_out == 10'h000 &&
		irq_req_out == 11'h000) else $error("outputs not quiet after reset");
	AST_RD_IDLE: assert property (!reg_req_in.rd |=>
		rd_data_out == 8'h00) else $error("read data without a read");
	AST_UNMAPPED: assert property (reg_req_in.rd && pg > 4'hA &&
		pg < 4'hF |=> rd_data_out == 8'h00) else $error("unmapped page read");
	AST_OFS_HOLE: assert property (reg_req_in.rd && ofs == 4'hF |=>
		rd_data_out == 8'h00) else $error("unmapped offset read");
	AST_GLOBAL_RSV: assert property (reg_req_in.rd && pg == 4'hF |=>
		rd_data_out[7:2] == 6'h00) else $error("select reserved bits set");
	AST_RUN_RSV: assert property (chan_rd(timer_array_pkg::OFS_RUN) |=>
		(rd_data_out & 8'hFA) == 8'h00) else $error("run reserved bits set");
	AST_CTRL_RSV: assert property (chan_rd(timer_array_pkg::OFS_CTRL) |=>
		rd_data_out[7:4] == 4'h0) else $error("control reserved bits set");
	AST_FF_RSV: assert property (chan_rd(timer_array_pkg::OFS_FFCTRL) |=>
		rd_data_out[7:6] == 2'h0) else $error("ff control reserved bits set");
	AST_ST_RSV: assert property (chan_rd(timer_array_pkg::OFS_STATUS) |=>
		rd_data_out[7:3] == 5'h00) else $error("status reserved bits set");
	AST_FF_CMD: assert property (ff_cmd |=> ##1
		flipflop_output_pin_out[$past(pg, 2)] == $past(reg_req_in.wdata[0], 2))
		else $error("flip-flop pin ignores set or clear");
endmodule : timer_event_array_assertions

// ---- verif/timer_event_array_bench.sv ----
// Purpose: Self-checking bench for the timer/event counter array
// Assumes: Byte register port, strobes driven right after the rising edge
// Notes: Timing windows allow for the unknown first prescaler phase
`timescale 1ns/1ps
module timer_event_array_bench;
	logic sys_clk_in = 1'b0;
	logic sys_rst_in = 1'b0;
	timer_array_pkg::bus_req_s reg_req_in = '0;
	logic [2:0] in0_drv = 3'h0;
	logic [2:0] in1_drv = 3'h0;
	logic [7:0] rd_data_out;
	logic [9:0] ff_pins;
	logic [10:0] irq_req_out;
	logic [7:0] got;
	int failures = 0;
	int checks_done = 0;
	int mdl [256];
	int n;
	int p;
	int ffcmd [4] = '{1, 2, 0, 3};
	logic [3:0] ffexp = 4'b1101;
	int pc [3] = '{0, 1, 10};
	// Free-running 10 MHz clock
	always #50 sys_clk_in = ~sys_clk_in;
	timer_event_array u_timer_event_array (.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in),
		.ext_clock_capture_in0_in(in0_drv), .ext_capture_in1_in(in1_drv),
		.rd_data_out(rd_data_out), .flipflop_output_pin_out(ff_pins),
		.irq_req_out(irq_req_out));
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e)
		begin
			$display("ERROR %0t: got %h expected %h", $time, g, e);
			failures++;
		end
	endtask : chk
	// One-cycle write strobe; the model follows the write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		reg_req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk_in);
		reg_req_in.wr <= 1'b0;
		mdl[a] = d;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_in);
		reg_req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk_in);
		reg_req_in.rd <= 1'b0;
		@(negedge sys_clk_in);
		got = rd_data_out;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(got, e);
	endtask : rc
	task automatic scan_all();
		for (int a = 0; a < 176; a++)
			if (a % 16 != 15)
				rc(8'(a), 8'(mdl[a]));
	endtask : scan_all
	// Bounded wait for a request line, or for a pin to change
	task automatic wait_bit(input int idx, input bit on_pin);
		logic s0;
		s0 = ff_pins[idx % 10];
		n = 0;
		while (on_pin ? ff_pins[idx % 10] === s0 : irq_req_out[idx] !== 1'b1)
		begin
			@(negedge sys_clk_in);
			n++;
			if (n > 3000)
			begin
				$display("ERROR %0t: wait ran out", $time);
				failures++;
				final_report();
			end
		end
	endtask : wait_bit
	task automatic pins(input logic [2:0] a, input logic [2:0] b);
		@(posedge sys_clk_in);
		in0_drv <= a;
		in1_drv <= b;
		repeat (3) @(posedge sys_clk_in);
	endtask : pins
	// Reset also returns the model to its power-up contents
	// Raised on a rising edge so a mid-run reset never lands mid-cycle
	task automatic do_reset();
		@(posedge sys_clk_in);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		foreach (mdl[i])
			mdl[i] = (i < 176 && i % 16 >= 7 && i % 16 <= 10) ? 8'hFF : 0;
	endtask : do_reset
	// Main sequence
	initial
	begin
		n = $urandom(32'h6CBB17C2);
		do_reset();
		scan_all();
		rc(8'hF0, 8'h00);
		rc(8'hB3, 8'h00);
		rc(8'h0F, 8'h00);
		// Random contents; the low byte of capture 0 must refuse writes
		for (int c = 0; c < 11; c++)
			for (int o = 1; o < 12; o++)
				if (o != 3 && o != 4)
				begin
					wr(8'(c * 16 + o), 8'($urandom));
					mdl[c * 16 + o] &= (o < 3) ? 8'h0F : (o < 11) ? 8'hFF : 0;
				end
		wr(8'hF0, 8'($urandom) & 8'h03);
		scan_all();
		rc(8'hF0, 8'(mdl[240]));
		do_reset();
		// Software flip-flop commands reach pins 0 to 9
		for (int c = 0; c < 10; c++)
			for (int k = 0; k < 4; k++)
			begin
				wr(8'(c * 16 + 3), 8'(ffcmd[k]));
				@(posedge sys_clk_in);
				@(negedge sys_clk_in);
				chk({7'h00, ff_pins[c]}, {7'h00, ffexp[k]});
			end
		do_reset();
		// Internal triggers: channel 9 for 0..4, channel 3 for the rest
		wr(8'h01, 8'h06);
		wr(8'h51, 8'h06);
		wr(8'h05, 8'h34);
		wr(8'h55, 8'h39);
		wr(8'h93, 8'h01);
		repeat (4) @(posedge sys_clk_in);
		rc(8'h0B, 8'h34);
		rc(8'h5B, 8'h00);
		wr(8'h33, 8'h01);
		wr(8'h93, 8'h02);
		repeat (4) @(posedge sys_clk_in);
		rc(8'h5B, 8'h39);
		rc(8'h0D, 8'h34);
		do_reset();
		// External capture pins exist on channels 0, 1 and 10 only
		wr(8'h21, 8'h02);
		wr(8'h25, 8'h77);
		for (int i = 0; i < 3; i++)
		begin
			wr(8'(pc[i] * 16 + 1), 8'h02);
			wr(8'(pc[i] * 16 + 5), 8'(8'h50 + i));
		end
		pins(3'h7, 3'h0);
		pins(3'h7, 3'h7);
		pins(3'h0, 3'h0);
		for (int i = 0; i < 3; i++)
		begin
			rc(8'(pc[i] * 16 + 11), 8'(8'h50 + i));
			rc(8'(pc[i] * 16 + 13), 8'(8'h50 + i));
		end
		rc(8'h2B, 8'h00);
		// Pulse width: rise and fall of one pin, counter preset between
		wr(8'h11, 8'h04);
		wr(8'h15, 8'h11);
		pins(3'h2, 3'h0);
		wr(8'h15, 8'h22);
		pins(3'h0, 3'h0);
		rc(8'h1B, 8'h11);
		rc(8'h1D, 8'h22);
		rc(8'h1C, 8'h00);
		do_reset();
		// Interval timing per input divide; a stop must clear the phase
		wr(8'h42, 8'h01);
		wr(8'h47, 8'h04);
		wr(8'h48, 8'h00);
		for (int s = 0; s < 4; s++)
		begin
			wr(8'hF0, 8'(s));
			wr(8'h40, 8'h05);
			wait_bit(4, 1'b0);
			p = 2 * (16 >> s);
			chk(8'(n >= 3 * p && n <= 4 * p + 6), 8'h01);
			rd(8'h44);
			chk(got & 8'h01, 8'h01);
			repeat (2) @(negedge sys_clk_in);
			chk({7'h00, irq_req_out[4]}, 8'h00);
			wr(8'h40, 8'h00);
			wr(8'h45, 8'h00);
		end
		// Overflow from the top count
		wr(8'h62, 8'h01);
		wr(8'h65, 8'hFF);
		wr(8'h66, 8'hFF);
		wr(8'h60, 8'h05);
		wait_bit(6, 1'b0);
		rd(8'h64);
		chk(got & 8'h04, 8'h04);
		wr(8'h60, 8'h00);
		// Event counting, then two-phase counting, on the last channel
		wr(8'hA2, 8'h04);
		wr(8'hA0, 8'h01);
		repeat (5)
		begin
			pins(3'h4, 3'h0);
			pins(3'h0, 3'h0);
		end
		rc(8'hA5, 8'h05);
		wr(8'hA0, 8'h00);
		wr(8'hA5, 8'h00);
		wr(8'hA2, 8'h0C);
		wr(8'hA0, 8'h01);
		pins(3'h4, 3'h0);
		pins(3'h4, 3'h4);
		pins(3'h0, 3'h4);
		pins(3'h0, 3'h0);
		rc(8'hA5, 8'h04);
		// Square wave: toggles at counts 2 and 5, three T1 steps apart
		wr(8'hF0, 8'h03);
		wr(8'h27, 8'h02);
		wr(8'h28, 8'h00);
		wr(8'h29, 8'h05);
		wr(8'h2A, 8'h00);
		wr(8'h22, 8'h09);
		wr(8'h23, 8'h0F);
		wr(8'h20, 8'h05);
		wait_bit(2, 1'b1);
		wait_bit(2, 1'b1);
		chk(8'(n), 8'h0C);
		final_report();
	end
endmodule : timer_event_array_bench
bind timer_event_array timer_event_array_assertions
	u_timer_event_array_assertions (.sys_clk_in(sys_clk_in),
	.sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in),
	.ext_clock_capture_in0_in(ext_clock_capture_in0_in),
	.ext_capture_in1_in(ext_capture_in1_in), .rd_data_out(rd_data_out),
	.flipflop_output_pin_out(flipflop_output_pin_out),
	.irq_req_out(irq_req_out));
